// File: rtl/debug_exec_defines.svh
`ifndef DEBUG_EXEC_DEFINES_SVH
`define DEBUG_EXEC_DEFINES_SVH

// Command codes
`define CMD_ENTER_DEBUG 8'h90
`define CMD_RD_IN_BYTE 8'hE4
`define CMD_RD_IN_WORD 8'hEC
`define CMD_RD_OUT_BYTE 8'hE0
`define CMD_RD_OUT_WORD 8'hE8
`define CMD_WR_IN_BYTE 8'hC4
`define CMD_WR_IN_WORD 8'hCC
`define CMD_WR_OUT_BYTE 8'hC0
`define CMD_WR_OUT_WORD 8'hC8
`define CMD_RD_NEXT 8'h62
`define CMD_RD_PC 8'h63
`define CMD_RD_SP 8'h67
`define CMD_WR_NEXT 8'h42
`define CMD_WR_PC 8'h43
`define CMD_WR_SP 8'h47
`define CMD_GO 8'h08
`define CMD_STEP 8'h10
`define CMD_TAG_GO 8'h18

// Debug map
`define STATUS_ADDR 16'hFF01
`define DBG_REG_LO 16'hFF00
`define DBG_REG_HI 16'hFF06
`define DBG_ROM_LO 16'hFF20
`define PERMIT_BIT 7
`define ACTIVE_BIT 6
`define TAG_BIT 5
`define STATUS_RESET 8'h00

// Timing
`define FREE_WAIT_CLOCKS 128
`define BIT_CLOCKS 16
`define BIT_SAMPLE_CLOCKS 10
`define TIMEOUT_CLOCKS 512
`define DRIVE_LOW_CLOCKS 13
`define SPEEDUP_CLOCK 7
`define FREE_WAIT_NS 2560
`define CLOCK_PERIOD_NS 20

`endif

// File: rtl/debug_exec_pkg.sv
package debug_exec_pkg;

    typedef enum logic [2:0]
    {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_MEM = 3'b011,
        ST_CPU = 3'b100,
        ST_SEND = 3'b101
    } phase_type;

    typedef struct packed
    {
        logic req;
        logic write;
        logic map_in;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0] strobe;
    } mem_req_type;

    typedef struct packed
    {
        logic req;
        logic write;
        logic [2:0] reg_sel;
        logic [15:0] wdata;
    } cpu_req_type;

endpackage

// File: rtl/debug_command_executor.sv
`timescale 1ns/1ps
`include "debug_exec_defines.svh"
module debug_command_executor
    import debug_exec_pkg::*;
#(
    parameter int FREE_WAIT = `FREE_WAIT_CLOCKS
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic debug_serial_pin_in,
    output logic debug_serial_pin_out,
    output logic debug_serial_pin_oe,
    input wire logic bus_free,
    output mem_req_type mem_req,
    output logic cpu_freeze,
    input wire logic [15:0] mem_rdata,
    output cpu_req_type cpu_req,
    input wire logic cpu_done,
    input wire logic [15:0] cpu_rdata,
    input wire logic cpu_halt_instruction,
    input wire logic step_done,
    output logic debug_mode,
    output logic tagging_enabled,
    output logic cpu_resume,
    output logic [7:0] command_reg
)
;
    // Steal after whichever limit runs out first: clock count or time budget
    localparam int FREE_WAIT_NS_COUNT = (`FREE_WAIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam int WAIT_LIMIT = (FREE_WAIT < FREE_WAIT_NS_COUNT) ? FREE_WAIT : FREE_WAIT_NS_COUNT;

    typedef struct packed
    {
        logic sync1;
        logic sync2;
        logic pin_prev;
        phase_type phase;
        logic in_bit;
        logic [4:0] bit_left;
        logic [4:0] bit_clk;
        logic [9:0] idle_cnt;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] shift;
        logic [7:0] wait_cnt;
        logic permit;
        logic active;
        logic tagging;
        logic stepping;
        logic drive_low;
        logic drive_high;
        logic send_bit;
        logic resume;
        logic freeze;
        mem_req_type mem;
        cpu_req_type cpu;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // Decode per command: needs address, firmware class, read
    function automatic logic needs_addr(input logic [7:0] c);
        needs_addr = c[7] && (c[6] || c[5:4] == 2'b00) && c != `CMD_ENTER_DEBUG;
    endfunction

    function automatic logic is_firmware(input logic [7:0] c);
        is_firmware = !c[7];
    endfunction

    function automatic logic is_read(input logic [7:0] c);
        is_read = c[5];
    endfunction

    // Phases in which the wire carries a field and bit timing runs
    function automatic logic in_frame(input phase_type p);
        in_frame = p == ST_CMD || p == ST_ADDR || p == ST_DATA || p == ST_SEND;
    endfunction

    // Operand-free codes that hand the CPU back to the user program
    function automatic logic is_resume(input logic [7:0] c);
        is_resume = c == `CMD_GO || c == `CMD_STEP || c == `CMD_TAG_GO;
    endfunction

    // Status byte image: permit, active, tagging, the rest read as zero
    function automatic logic [15:0] status_word(input logic p, input logic a, input logic t);
        status_word = {8'h00, p, a, t, 5'b00000};
    endfunction

    // Byte lanes: word uses both, odd address low lane, even high
    function automatic logic [1:0] lane_strobe(input logic [7:0] c, input logic [15:0] a);
        lane_strobe = c[3] ? 2'b11 : (a[0] ? 2'b01 : 2'b10);
    endfunction

    logic falling;
    logic status_hit;

    always_comb
    begin
        state_next = state_reg;
        // Two-flop sync, then one more flop for edge detection
        state_next.sync1 = debug_serial_pin_in;
        state_next.sync2 = state_reg.sync1;
        state_next.pin_prev = state_reg.sync2;
        // Strobes are one-cycle pulses unless a branch below raises them
        state_next.resume = 1'b0;
        state_next.mem.req = 1'b0;
        state_next.freeze = 1'b0;
        state_next.cpu.req = 1'b0;
        falling = state_reg.pin_prev && !state_reg.sync2;
        status_hit = 1'b0;

        // Idle timeout clears the command and the frame
        // Counter saturates so a long quiet line never wraps into a match
        if (falling)
            state_next.idle_cnt = '0;
        else if (state_reg.idle_cnt != 10'(`TIMEOUT_CLOCKS))
            state_next.idle_cnt = state_reg.idle_cnt + 10'd1;
        if (state_reg.idle_cnt == 10'(`TIMEOUT_CLOCKS - 1) && !falling
            && in_frame(state_reg.phase))
        begin
            state_next.cmd = 8'h00;
            state_next.phase = ST_CMD;
            state_next.bit_left = 5'd8;
            state_next.in_bit = 1'b0;
            state_next.drive_low = 1'b0;
            state_next.drive_high = 1'b0;
        end

        // Bit timing: each bit starts on a host falling edge
        // Edges inside a bit are ignored: our own low drive echoes back
        else if (falling && !state_reg.in_bit && in_frame(state_reg.phase))
        begin
            state_next.in_bit = 1'b1;
            state_next.bit_clk = 5'd0;
            state_next.send_bit = state_reg.shift[15];
        end
        else if (state_reg.in_bit)
        begin
            state_next.bit_clk = state_reg.bit_clk + 5'd1;
            if (state_reg.phase == ST_SEND)
            begin
                // Read data leaves from the top of the same shift register
                // Zero is held low; speed-up pulse makes a one rise fast
                state_next.drive_low = !state_reg.send_bit
                    && state_reg.bit_clk < 5'(`DRIVE_LOW_CLOCKS - 1);
                state_next.drive_high = state_reg.send_bit
                    ? state_reg.bit_clk == 5'(`SPEEDUP_CLOCK - 1)
                    : state_reg.bit_clk == 5'(`DRIVE_LOW_CLOCKS - 1);
            end
            if (state_reg.bit_clk == 5'(`BIT_SAMPLE_CLOCKS - 1))
            begin
                // MSB first
                state_next.shift = {state_reg.shift[14:0], state_reg.sync2};
                state_next.bit_left = state_reg.bit_left - 5'd1;
            end
            if (state_reg.bit_clk == 5'(`BIT_CLOCKS - 2))
            begin
                state_next.in_bit = 1'b0;
                state_next.drive_high = 1'b0;
            end
        end

        // Frame sequencing once a field is complete
        // A field is taken only after its last bit has fully ended
        if (state_reg.bit_left == 5'd0 && !state_reg.in_bit)
        begin
            state_next.bit_left = 5'd16;
            case (state_reg.phase)
                ST_CMD:
                begin
                    state_next.cmd = state_reg.shift[7:0];
                    if (state_reg.shift[7:0] == `CMD_ENTER_DEBUG)
                    begin
                        if (state_reg.permit)
                            state_next.active = 1'b1;
                        state_next.bit_left = 5'd8;
                    end
                    else if (needs_addr(state_reg.shift[7:0]))
                        state_next.phase = ST_ADDR;
                    else if (!state_reg.active)
                        state_next.bit_left = 5'd8;
                    else if (is_firmware(state_reg.shift[7:0]) && state_reg.shift[6])
                    begin
                        // Firmware register access, read or write
                        if (is_read(state_reg.shift[7:0]))
                            state_next.phase = ST_CPU;
                        else
                            state_next.phase = ST_DATA;
                    end
                    else
                    begin
                        // Operand-free resume commands
                        state_next.bit_left = 5'd8;
                        // Unknown operand-free codes are dropped here
                        if (is_resume(state_reg.shift[7:0]))
                        begin
                            state_next.active = 1'b0;
                            state_next.resume = 1'b1;
                            state_next.stepping = state_reg.shift[7:0] == `CMD_STEP;
                            state_next.tagging = state_reg.shift[7:0] == `CMD_TAG_GO;
                        end
                    end
                end
                ST_ADDR:
                begin
                    state_next.addr = state_reg.shift;
                    state_next.phase = is_read(state_reg.cmd) ? ST_MEM : ST_DATA;
                end
                ST_DATA:
                    state_next.phase = is_firmware(state_reg.cmd) ? ST_CPU : ST_MEM;
                default:
                    state_next.phase = ST_CMD;
            endcase
            if (state_next.phase == ST_MEM || state_next.phase == ST_CPU
                || state_next.phase == ST_CMD)
                state_next.bit_left = state_next.phase == ST_CMD ? 5'd8 : 5'd16;
            state_next.wait_cnt = 8'd0;
        end

        // Hardware memory access: free cycle or steal
        if (state_reg.phase == ST_MEM && state_reg.bit_left != 5'd0)
        begin
            state_next.mem.write = !is_read(state_reg.cmd);
            state_next.mem.map_in = state_reg.cmd[2] && state_reg.active;
            state_next.mem.addr = state_reg.addr;
            // Byte lanes: even address high byte, odd low byte
            state_next.mem.strobe = lane_strobe(state_reg.cmd, state_reg.addr);
            state_next.mem.wdata = state_reg.shift;
            status_hit = state_reg.cmd[2] && state_reg.addr == `STATUS_ADDR;
            if (bus_free || state_reg.wait_cnt == 8'(WAIT_LIMIT))
            begin
                state_next.freeze = !bus_free;
                if (status_hit)
                begin
                    // Status byte lives here, odd address so low lane
                    // Only the permit bit is writable; the other bits are status
                    if (!is_read(state_reg.cmd))
                        state_next.permit = state_reg.shift[`PERMIT_BIT];
                    state_next.shift = status_word(state_reg.permit, state_reg.active,
                        state_reg.tagging);
                end
                else
                    state_next.mem.req = 1'b1;
                state_next.phase = is_read(state_reg.cmd) ? ST_SEND : ST_CMD;
                state_next.bit_left = is_read(state_reg.cmd) ? 5'd16 : 5'd8;
            end
            else
                state_next.wait_cnt = state_reg.wait_cnt + 8'd1;
        end

        // Read data is taken in the cycle of the request pulse itself, full word
        // Memory must present its data in the same cycle as the pulse
        if (state_reg.mem.req && !state_reg.mem.write)
            state_next.shift = mem_rdata;

        // Firmware register access through the CPU
        if (state_reg.phase == ST_CPU)
        begin
            state_next.cpu.write = !is_read(state_reg.cmd);
            state_next.cpu.reg_sel = state_reg.cmd[2:0];
            state_next.cpu.wdata = state_reg.shift;
            // Request stays up until the CPU side answers
            state_next.cpu.req = !cpu_done;
            if (cpu_done)
            begin
                if (is_read(state_reg.cmd))
                    state_next.shift = cpu_rdata;
                state_next.phase = is_read(state_reg.cmd) ? ST_SEND : ST_CMD;
                state_next.bit_left = is_read(state_reg.cmd) ? 5'd16 : 5'd8;
            end
        end

        // Halt instruction or end of step re-enters debug mode when permitted
        // Without permit a halt is ignored and the user program runs on
        if ((cpu_halt_instruction || (step_done && state_reg.stepping)) && state_reg.permit)
        begin
            state_next.active = 1'b1;
            state_next.stepping = 1'b0;
            state_next.tagging = 1'b0;
        end
    end

    // Single state register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
            // Sync chain starts at the idle level, so no false edge follows
            state_reg.sync1 <= 1'b1;
            state_reg.sync2 <= 1'b1;
            state_reg.pin_prev <= 1'b1;
            state_reg.phase <= ST_CMD;
            state_reg.bit_left <= 5'd8;
        end
        else
            state_reg <= state_next;
    end

    // Open-drain style drive, enable high while driving
    // Pin level is high only during the speed-up pulse of a one and the pulse that ends a zero's low drive
    assign debug_serial_pin_oe = state_reg.drive_low || state_reg.drive_high;
    assign debug_serial_pin_out = state_reg.drive_high;
    assign mem_req = state_reg.mem;
    assign cpu_freeze = state_reg.freeze;
    assign cpu_req = state_reg.cpu;
    assign debug_mode = state_reg.active;
    assign tagging_enabled = state_reg.tagging;
    assign cpu_resume = state_reg.resume;
    assign command_reg = state_reg.cmd;
endmodule

// File: testbench/debug_exec_sva.sv
`timescale 1ns/1ps
module debug_exec_sva
    import debug_exec_pkg::*;
#(
    parameter int FREE_WAIT = 128
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic debug_serial_pin_in,
    input wire logic debug_serial_pin_out,
    input wire logic debug_serial_pin_oe,
    input wire logic bus_free,
    input wire mem_req_type mem_req,
    input wire logic cpu_freeze,
    input wire logic [15:0] mem_rdata,
    input wire cpu_req_type cpu_req,
    input wire logic cpu_done,
    input wire logic [15:0] cpu_rdata,
    input wire logic cpu_halt_instruction,
    input wire logic step_done,
    input wire logic debug_mode,
    input wire logic tagging_enabled,
    input wire logic cpu_resume,
    input wire logic [7:0] command_reg
);
    logic [9:0] idle_reg;

    // Cycles since the wire was last low; saturates so a long idle never wraps
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            idle_reg <= 10'h000;
        else if (!debug_serial_pin_in)
            idle_reg <= 10'h000;
        else if (idle_reg != 10'h3FF)
            idle_reg <= idle_reg + 10'h001;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Relations between stimulus and the block's outputs
    property p_steal_busy; cpu_freeze |-> !$past(bus_free); endproperty
    a_steal_busy: assert property (p_steal_busy) else $error("stole a free cycle");
    property p_byte_lane; mem_req.req && mem_req.strobe != 2'h3
        |-> mem_req.strobe == (mem_req.addr[0] ? 2'h1 : 2'h2); endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");
    property p_map_mode; mem_req.req && mem_req.map_in |-> debug_mode; endproperty
    a_map_mode: assert property (p_map_mode) else $error("mapped in outside mode");
    property p_fw_mode; cpu_req.req |-> debug_mode; endproperty
    a_fw_mode: assert property (p_fw_mode) else $error("firmware outside mode");
    property p_mem_pulse; mem_req.req |=> !mem_req.req; endproperty
    a_mem_pulse: assert property (p_mem_pulse) else $error("request not a pulse");
    property p_zero_low; $rose(debug_serial_pin_oe && !debug_serial_pin_out)
        |-> (debug_serial_pin_oe && !debug_serial_pin_out) [*8]; endproperty
    a_zero_low: assert property (p_zero_low) else $error("zero bit too short");
    property p_cpu_hold; cpu_req.req && !cpu_done
        |=> cpu_req.req && $stable(cpu_req.reg_sel) && $stable(cpu_req.wdata); endproperty
    a_cpu_hold: assert property (p_cpu_hold) else $error("cpu request dropped");
    property p_timeout; idle_reg == 10'h230 |-> command_reg == 8'h00; endproperty
    a_timeout: assert property (p_timeout) else $error("command kept past idle");

    // Main scenarios reached
    c_steal: cover property (cpu_freeze);
    c_fw_write: cover property (cpu_req.req && cpu_req.write);
    c_enter: cover property ($rose(debug_mode));
endmodule

// File: testbench/debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model
(
    input wire logic clock,
    input wire logic pin,
    output logic host_low
);
    initial host_low = 1'b0;

    // Field out, top bit first; long low for 0, short low for 1
    task automatic send(input logic [15:0] d, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            host_low = 1'b1;
            repeat (d[i] ? 3 : 16) @(posedge clock);
            #1 host_low = 1'b0;
            repeat (d[i] ? 21 : 8) @(posedge clock);
            #1;
        end
    endtask

    // Field in; brief low opens each bit, then the wire is left to the device
    task automatic recv(output logic [15:0] d);
        for (int i = 15; i >= 0; i--)
        begin
            host_low = 1'b1;
            repeat (2) @(posedge clock);
            #1 host_low = 1'b0;
            repeat (10) @(posedge clock);
            #1 d[i] = pin;
            repeat (14) @(posedge clock);
            #1;
        end
    endtask
endmodule

// File: testbench/debug_command_executor_tb.sv
`timescale 1ns/1ps
module debug_command_executor_tb;
    import debug_exec_pkg::*;
    logic clock, rst_n, bus_free, cpu_done, step_done, host_low, debug_serial_pin_in;
    logic debug_serial_pin_out, debug_serial_pin_oe, cpu_freeze, debug_mode;
    logic tagging_enabled, cpu_resume;
    logic [15:0] mem_rdata, cpu_rdata, v;
    logic halt;
    logic [7:0] command_reg;
    mem_req_type mem_req, last_mem;
    cpu_req_type cpu_req, last_cpu;
    int failures = 0, tests_run = 0, cycles = 0, freezes = 0, cpu_reqs = 0, resumes = 0;

    // Pull-up wins whenever nobody drives the wire
    assign debug_serial_pin_in = debug_serial_pin_oe ? debug_serial_pin_out : !host_low;
    // Memory stand-in answers at once, so data stands in the same cycle as the pulse
    assign mem_rdata = (mem_req.addr & 16'hFFFE) ^ 16'h5A5A;

    debug_command_executor #(.FREE_WAIT(128)) i_dut (.clock, .rst_n, .debug_serial_pin_in,
        .debug_serial_pin_out, .debug_serial_pin_oe, .bus_free, .mem_req, .cpu_freeze,
        .mem_rdata, .cpu_req, .cpu_done, .cpu_rdata, .cpu_halt_instruction(halt),
        .step_done, .debug_mode, .tagging_enabled, .cpu_resume, .command_reg);
    debug_host_model i_host (.clock, .pin(debug_serial_pin_in), .host_low);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Memory and CPU stand-ins; counts; hang guard sized well above the run
    always @(posedge clock)
    begin
        if (mem_req.req)
            last_mem <= mem_req;
        if (cpu_req.req && !cpu_done)
            cpu_reqs++;
        if (cpu_req.req)
            last_cpu <= cpu_req;
        cpu_done <= #1 cpu_req.req && !cpu_done;
        cpu_rdata <= #1 {13'h1800, cpu_req.reg_sel};
        freezes += cpu_freeze;
        resumes += cpu_resume;
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            $display("mismatch run_length expected finish seen hang");
            conclude();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Hardware frames; the pause covers the longest wait for a free cycle
    task automatic hw(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
        i_host.send(16'(c), 8);
        i_host.send(a, 16);
        if (!c[5])
            i_host.send(d, 16);
        repeat (150) @(posedge clock);
        #1;
        if (c[5])
            i_host.recv(v);
    endtask

    // Firmware frames; read when bit 5 set, data sent when n set
    task automatic fw(input logic [7:0] c, input logic [15:0] d, input bit n);
        i_host.send(16'(c), 8);
        if (n)
            i_host.send(d, 16);
        repeat (64) @(posedge clock);
        #1;
        if (c[5])
            i_host.recv(v);
    endtask

    function automatic logic [15:0] lane();
        return {12'h000, last_mem.write, last_mem.map_in, last_mem.strobe};
    endfunction

    task automatic t_refused();
        fw(8'h43, 16'h1234, 1);
        fw(8'h90, 16'h0000, 0);
        chk("fw_outside", 16'h0000, 16'(cpu_reqs));
        chk("enter_no_permit", 16'h0000, {15'h0, debug_mode});
    endtask

    task automatic t_user_mem();
        hw(8'hE8, 16'h2468, 16'h0000);
        chk("rd_word", 16'h7E32, v);
        chk("rd_word_lane", 16'h0003, lane());
        hw(8'hC8, 16'h2468, 16'hBEEF);
        chk("wr_word", 16'hBEEF, last_mem.wdata);
        chk("wr_word_lane", 16'h000B, lane());
        hw(8'hC0, 16'h1234, 16'h7700);
        chk("wr_byte_lane", 16'h000A, lane());
        bus_free = 1'b0;
        hw(8'hE0, 16'h1235, 16'h0000);
        bus_free = 1'b1;
        chk("steal", 16'h0001, 16'(freezes));
        chk("rd_byte_odd", 16'h006E, v & 16'h00FF);
        chk("rd_byte_lane", 16'h0001, lane());
    endtask

    task automatic t_enter();
        hw(8'hE4, 16'hFF01, 16'h0000);
        chk("status_user", 16'h0000, v);
        hw(8'hC4, 16'hFF01, v | 16'h0080);
        hw(8'hE4, 16'hFF01, 16'h0000);
        chk("status_permit", 16'h0080, v);
        fw(8'h90, 16'h0000, 0);
        chk("enter", 16'h0001, {15'h0, debug_mode});
        hw(8'hE4, 16'hFF01, 16'h0000);
        chk("status_active", 16'h00C0, v);
        hw(8'hEC, 16'h2000, 16'h0000);
        chk("rd_in_lane", 16'h0007, lane());
        hw(8'hCC, 16'h2000, 16'h1357);
        chk("wr_in_lane", 16'h000F, lane());
    endtask

    task automatic t_cpu_regs();
        for (int i = 2; i < 8; i++)
        begin
            fw(8'(8'h60 + i), 16'h0000, 0);
            chk("fw_rd", 16'hC000 | 16'(i), v);
            chk("fw_rd_sel", 16'(i), {12'h000, last_cpu.write, last_cpu.reg_sel});
            fw(8'(8'h40 + i), 16'h4400 + 16'(i), 1);
            chk("fw_wr_sel", 16'(8 + i), {12'h000, last_cpu.write, last_cpu.reg_sel});
            chk("fw_wr_data", 16'h4400 + 16'(i), last_cpu.wdata);
        end
    endtask

    task automatic t_leave();
        fw(8'h10, 16'h0000, 0);
        step_done = 1'b1;
        @(posedge clock);
        #1 step_done = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk("step", 16'h0001, 16'(resumes));
        chk("step_back", 16'h0001, {15'h0, debug_mode});
        fw(8'h08, 16'h0000, 0);
        chk("go", 16'h0002, {15'h0, debug_mode} + 16'(resumes));
        fw(8'h90, 16'h0000, 0);
        fw(8'h18, 16'h0000, 0);
        chk("tag_go", 16'h0002, {14'h0, tagging_enabled, debug_mode});
        halt = 1'b1;
        @(posedge clock);
        #1 halt = 1'b0;
        hw(8'hE4, 16'hFF01, 16'h0000);
        chk("status_halt", 16'h00C0, v);
        fw(8'h08, 16'h0000, 0);
    endtask

    task automatic t_timeout();
        i_host.send(16'h000A, 4);
        repeat (600) @(posedge clock);
        #1;
        chk("cmd_cleared", 16'h0000, {8'h00, command_reg});
        hw(8'hE4, 16'hFF01, 16'h0000);
        chk("resync", 16'h0080, v & 16'h00C0);
    endtask

    task automatic conclude();
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        rst_n = 1'b0;
        bus_free = 1'b1;
        step_done = 1'b0;
        cpu_done = 1'b0;
        halt = 1'b0;
        cpu_rdata = 16'h0000;
        repeat (8) @(posedge clock);
        chk("oe_reset", 16'h0000, {14'h0, debug_serial_pin_oe, debug_mode});
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        t_refused();
        t_user_mem();
        t_enter();
        t_cpu_regs();
        t_leave();
        t_timeout();
        conclude();
    end
endmodule

bind debug_command_executor debug_exec_sva #(.FREE_WAIT(FREE_WAIT)) i_sva (.clock, .rst_n,
    .debug_serial_pin_in, .debug_serial_pin_out, .debug_serial_pin_oe, .bus_free, .mem_req,
    .cpu_freeze, .mem_rdata, .cpu_req, .cpu_done, .cpu_rdata, .cpu_halt_instruction,
    .step_done, .debug_mode, .tagging_enabled, .cpu_resume, .command_reg);
